// file: logic/fac_check_dev.sv
// device end: fp access check, lazy save trigger, system register space
`default_nettype none
module fac_check_dev
  import fac_pkg::*;
(
  input  wire  logic        ref_clk,
  input  wire  logic        reset,
  fac_if.dev                fif,
  input  wire  logic        bank_wr_en,
  input  wire  logic [4:0]  bank_wr_sidx,
  input  wire  logic [31:0] bank_wr_data,
  input  wire  logic [4:0]  bank_rd_sidx,
  input  wire  logic [3:0]  bank_rd_didx,
  output logic [31:0]       bank_rd_sdata,
  output logic [63:0]       bank_rd_ddata,
  output logic [31:0]       fp_status_control,
  output logic              usage_fault_status_no_coprocessor_flag,
  output logic              fields_mismatch
);
  logic [31:0] fpsc_ff;
  logic        ctx_ff;
  logic        no_coprocessor_flag_ff;
  logic        busy_ff;
  logic        rsp_valid_ff;
  logic        rsp_fault_ff;
  logic        rsp_save_ff;
  logic        rsp_rsvd_ff;
  logic [31:0] rsp_rdata_ff;
  logic        take;
  logic        permit;
  logic        waiting_save;
  logic        finish;

  fac_regbank u_bank (
    .ref_clk  (ref_clk),
    .reset    (reset),
    .wr_en    (bank_wr_en),
    .wr_sidx  (bank_wr_sidx),
    .wr_data  (bank_wr_data),
    .rd_sidx  (bank_rd_sidx),
    .rd_didx  (bank_rd_didx),
    .rd_sdata (bank_rd_sdata),
    .rd_ddata (bank_rd_ddata)
  );

  // a second request is held off until the answer has been given
  assign fif.req_ready = !busy_ff && !rsp_valid_ff;
  assign take = fif.req_valid && fif.req_ready;
  // field 10 is unpredictable; treated as denial to stay safe
  assign permit = fac_permitted(fif.access_lo, fif.req_priv);
  assign fields_mismatch = fif.access_lo != fif.access_hi;
  assign waiting_save = busy_ff && fif.lazy_preserve_active;
  assign finish = busy_ff && !fif.lazy_preserve_active;

  // busy covers the wait for an outstanding lazy save
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      busy_ff <= 1'b0;
    end else if (take && permit && fif.req_op == FAC_OP_EXEC) begin
      busy_ff <= 1'b1;
    end else if (finish) begin
      busy_ff <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      no_coprocessor_flag_ff <= 1'b0;
    end else if (take && !permit) begin
      no_coprocessor_flag_ff <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      fpsc_ff <= FAC_STATUS_CONTROL_RST;
      ctx_ff  <= 1'b0;
    end else if (finish && fif.auto_preserve_enable && !ctx_ff) begin
      fpsc_ff[FAC_DEFAULT_HI:FAC_DEFAULT_LO] <=
        fif.fp_default_status_control[FAC_DEFAULT_HI:FAC_DEFAULT_LO];
      ctx_ff <= 1'b1;
    end else if (take && permit && fif.req_op == FAC_OP_WRSYS &&
                 fif.req_idx == FAC_IDX_STATUS_CONTROL) begin
      fpsc_ff <= fif.req_wdata;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rsp_valid_ff <= 1'b0;
      rsp_fault_ff <= 1'b0;
      rsp_save_ff  <= 1'b0;
      rsp_rsvd_ff  <= 1'b0;
      rsp_rdata_ff <= 32'h0000_0000;
    end else begin
      rsp_valid_ff <= 1'b0;
      rsp_save_ff  <= waiting_save;
      if (take && !permit) begin
        rsp_valid_ff <= 1'b1;
        rsp_fault_ff <= 1'b1;
        rsp_rsvd_ff  <= 1'b0;
        rsp_rdata_ff <= 32'h0000_0000;
      end else if (take && fif.req_op != FAC_OP_EXEC) begin
        rsp_valid_ff <= 1'b1;
        rsp_fault_ff <= 1'b0;
        rsp_rsvd_ff  <= fif.req_idx != FAC_IDX_STATUS_CONTROL;
        rsp_rdata_ff <= (fif.req_idx == FAC_IDX_STATUS_CONTROL &&
                         fif.req_op == FAC_OP_RDSYS) ? fpsc_ff
                                                      : 32'h0000_0000;
      end else if (finish) begin
        rsp_valid_ff <= 1'b1;
        rsp_fault_ff <= 1'b0;
        rsp_rsvd_ff  <= 1'b0;
        rsp_rdata_ff <= 32'h0000_0000;
      end
    end
  end

  assign fif.rsp_valid               = rsp_valid_ff;
  assign fif.rsp_usage_fault_a       = rsp_fault_ff;
  assign fif.rsp_no_coprocessor_flag = no_coprocessor_flag_ff;
  assign fif.rsp_save_req            = rsp_save_ff;
  assign fif.rsp_reserved            = rsp_rsvd_ff;
  assign fif.rsp_rdata               = rsp_rdata_ff;
  assign fif.fp_context_active       = ctx_ff;
  assign fp_status_control           = fpsc_ff;
  assign usage_fault_status_no_coprocessor_flag     = no_coprocessor_flag_ff;
endmodule : fac_check_dev
`default_nettype wire

// file: logic/fac_ctrl_host.sv
// host end: axi4-lite register file driving requests into the check unit
`default_nettype none
module fac_ctrl_host
  import fac_pkg::*;
(
  input  wire  logic        ref_clk,
  input  wire  logic        reset,
  fac_if.host               fif,
  input  wire  logic [7:0]  s_awaddr,
  input  wire  logic        s_awvalid,
  output logic              s_awready,
  input  wire  logic [31:0] s_wdata,
  input  wire  logic [3:0]  s_wstrb,
  input  wire  logic        s_wvalid,
  output logic              s_wready,
  output logic [1:0]        s_bresp,
  output logic              s_bvalid,
  input  wire  logic        s_bready,
  input  wire  logic [7:0]  s_araddr,
  input  wire  logic        s_arvalid,
  output logic              s_arready,
  output logic [31:0]       s_rdata,
  output logic [1:0]        s_rresp,
  output logic              s_rvalid,
  input  wire  logic        s_rready,
  output logic              irq
);
  logic [31:0] ctrl_ff;
  logic [31:0] access_ff;
  logic [31:0] dflt_ff;
  logic [2:0]  status_ff;
  logic [2:0]  mask_ff;
  logic [31:0] sysw_ff;
  logic [31:0] result_ff;
  logic [7:0]  awaddr_ff;
  logic [31:0] wdata_ff;
  logic        aw_ff;
  logic        w_ff;
  fac_hstate_t st_ff;
  logic [5:0]  cmd_ff;
  logic        do_wr;
  logic        cmd_go;
  logic [2:0]  ev;
  logic [2:0]  wclr;

  assign s_awready = !aw_ff && !s_bvalid;
  assign s_wready  = !w_ff && !s_bvalid;
  assign do_wr = aw_ff && w_ff && !s_bvalid;
  assign cmd_go = do_wr && awaddr_ff == FAC_OFF_CMD && st_ff == FAC_ST_IDLE;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      aw_ff <= 1'b0;
      w_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff <= 32'h0000_0000;
      s_bvalid <= 1'b0;
      s_bresp <= FAC_RESP_OKAY;
    end else begin
      if (s_awvalid && s_awready) begin
        aw_ff <= 1'b1;
        awaddr_ff <= s_awaddr;
      end
      if (s_wvalid && s_wready) begin
        w_ff <= 1'b1;
        wdata_ff <= s_wdata;
      end
      if (do_wr) begin
        aw_ff <= 1'b0;
        w_ff <= 1'b0;
        s_bvalid <= 1'b1;
        s_bresp <= (awaddr_ff > FAC_OFF_CMD || awaddr_ff[1:0] != 2'h0)
                   ? FAC_RESP_SLVERR : FAC_RESP_OKAY;
      end else if (s_bvalid && s_bready) begin
        s_bvalid <= 1'b0;
      end
    end
  end

  // byte strobes are ignored: registers take whole words
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ctrl_ff <= 32'h0000_0000;
      access_ff <= 32'h0000_0000;
      dflt_ff <= 32'h0000_0000;
      mask_ff <= 3'h0;
      sysw_ff <= 32'h0000_0000;
      cmd_ff <= 6'h00;
    end else if (do_wr) begin
      case (awaddr_ff)
        FAC_OFF_CTRL:    ctrl_ff <= wdata_ff;
        FAC_OFF_ACCESS:  access_ff <= wdata_ff;
        FAC_OFF_DEFAULT: dflt_ff <= wdata_ff;
        FAC_OFF_MASK:    mask_ff <= wdata_ff[2:0];
        FAC_OFF_SYSREG:  sysw_ff <= wdata_ff;
        FAC_OFF_CMD:     cmd_ff <= cmd_go ? wdata_ff[5:0] : cmd_ff;
        default:         cmd_ff <= cmd_ff;
      endcase
    end
  end

  // ctrl: [0] auto_preserve_enable, [1] lazy active, [2] save done, [3] privileged
  assign fif.access_lo = access_ff[1:0];
  assign fif.access_hi = access_ff[3:2];
  assign fif.auto_preserve_enable = ctrl_ff[0];
  assign fif.lazy_preserve_active = ctrl_ff[1];
  assign fif.save_done = ctrl_ff[2];
  assign fif.req_priv = ctrl_ff[3];
  assign fif.fp_default_status_control = dflt_ff;
  assign fif.req_op = fac_op_t'(cmd_ff[1:0]);
  assign fif.req_idx = cmd_ff[5:2];
  assign fif.req_wdata = sysw_ff;
  assign fif.req_valid = st_ff == FAC_ST_REQ;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      st_ff <= FAC_ST_IDLE;
    end else begin
      case (st_ff)
        FAC_ST_IDLE: st_ff <= cmd_go ? FAC_ST_REQ : FAC_ST_IDLE;
        FAC_ST_REQ:  st_ff <= fif.req_ready ? FAC_ST_WAIT : FAC_ST_REQ;
        FAC_ST_WAIT: st_ff <= fif.rsp_valid ? FAC_ST_IDLE : FAC_ST_WAIT;
        default:     st_ff <= FAC_ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      result_ff <= 32'h0000_0000;
    end else if (st_ff == FAC_ST_WAIT && fif.rsp_valid) begin
      result_ff <= fif.rsp_rdata;
    end
  end

  assign ev[FAC_ST_DONE]  = st_ff == FAC_ST_WAIT && fif.rsp_valid;
  assign ev[FAC_ST_FAULT] = ev[FAC_ST_DONE] && fif.rsp_usage_fault_a;
  assign ev[FAC_ST_SAVE]  = fif.rsp_save_req;
  assign wclr = (do_wr && awaddr_ff == FAC_OFF_STATUS) ? wdata_ff[2:0]
                                                       : 3'h0;

  // set wins over a write-one clear in the same cycle
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      status_ff <= 3'h0;
    end else begin
      status_ff <= (status_ff & ~wclr) | ev;
    end
  end

  assign irq = |(status_ff & mask_ff);

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      s_rvalid <= 1'b0;
      s_rdata <= 32'h0000_0000;
      s_rresp <= FAC_RESP_OKAY;
    end else if (s_arvalid && s_arready) begin
      s_rvalid <= 1'b1;
      s_rresp <= FAC_RESP_OKAY;
      case (s_araddr)
        FAC_OFF_CTRL:    s_rdata <= ctrl_ff;
        FAC_OFF_ACCESS:  s_rdata <= access_ff;
        FAC_OFF_DEFAULT: s_rdata <= dflt_ff;
        FAC_OFF_STATUS:  s_rdata <= {27'h0, fif.fp_context_active,
                                     fif.rsp_no_coprocessor_flag, status_ff};
        FAC_OFF_MASK:    s_rdata <= {29'h0, mask_ff};
        FAC_OFF_SYSREG:  s_rdata <= sysw_ff;
        FAC_OFF_CMD:     s_rdata <= {24'h0, st_ff != FAC_ST_IDLE,
                                     fif.rsp_reserved, cmd_ff};
        FAC_OFF_RESULT:  s_rdata <= result_ff;
        default: begin
          s_rdata <= 32'h0000_0000;
          s_rresp <= FAC_RESP_SLVERR;
        end
      endcase
    end else if (s_rvalid && s_rready) begin
      s_rvalid <= 1'b0;
    end
  end

  assign s_arready = !s_rvalid;
endmodule : fac_ctrl_host
`default_nettype wire

// file: logic/fac_if.sv
// interface between pipeline-side controller and the check unit
`default_nettype none
interface fac_if;
  import fac_pkg::*;
  logic        req_valid;
  logic        req_ready;
  fac_op_t     req_op;
  logic        req_priv;
  logic [3:0]  req_idx;
  logic [31:0] req_wdata;
  logic [1:0]  access_lo;
  logic [1:0]  access_hi;
  logic        auto_preserve_enable;
  logic [31:0] fp_default_status_control;
  logic        lazy_preserve_active;
  logic        save_done;
  logic        rsp_valid;
  logic        rsp_usage_fault_a;
  logic        rsp_no_coprocessor_flag;
  logic        rsp_save_req;
  logic        rsp_reserved;
  logic [31:0] rsp_rdata;
  logic        fp_context_active;
  modport dev (input req_valid, req_op, req_priv, req_idx, req_wdata,
               access_lo, access_hi, auto_preserve_enable,
               fp_default_status_control, lazy_preserve_active, save_done,
               output req_ready, rsp_valid, rsp_usage_fault_a,
               rsp_no_coprocessor_flag, rsp_save_req, rsp_reserved,
               rsp_rdata, fp_context_active);
  modport host (output req_valid, req_op, req_priv, req_idx, req_wdata,
                access_lo, access_hi, auto_preserve_enable,
                fp_default_status_control, lazy_preserve_active, save_done,
                input req_ready, rsp_valid, rsp_usage_fault_a,
                rsp_no_coprocessor_flag, rsp_save_req, rsp_reserved,
                rsp_rdata, fp_context_active);
endinterface : fac_if
`default_nettype wire

// file: logic/fac_pkg.sv
// shared constants and types for the floating-point access check unit
`default_nettype none
package fac_pkg;
  localparam int unsigned FAC_SYSREG_IDX_W = 4;
  localparam logic [3:0]  FAC_IDX_STATUS_CONTROL = 4'h1;
  localparam int unsigned FAC_NUM_SREG = 32;
  localparam int unsigned FAC_NUM_DREG = 16;
  localparam int unsigned FAC_DEFAULT_HI = 26;
  localparam int unsigned FAC_DEFAULT_LO = 22;
  localparam logic [31:0] FAC_STATUS_CONTROL_RST = 32'h0000_0000;
  localparam logic [1:0]  FAC_ACC_DENY = 2'h0;
  localparam logic [1:0]  FAC_ACC_PRIV = 2'h1;
  localparam logic [1:0]  FAC_ACC_RSVD = 2'h2;
  localparam logic [1:0]  FAC_ACC_FULL = 2'h3;
  // host-side register offsets (byte addresses)
  localparam logic [7:0]  FAC_OFF_CTRL    = 8'h00;
  localparam logic [7:0]  FAC_OFF_ACCESS  = 8'h04;
  localparam logic [7:0]  FAC_OFF_DEFAULT = 8'h08;
  localparam logic [7:0]  FAC_OFF_STATUS  = 8'h0c;
  localparam logic [7:0]  FAC_OFF_MASK    = 8'h10;
  localparam logic [7:0]  FAC_OFF_SYSREG  = 8'h14;
  localparam logic [7:0]  FAC_OFF_CMD     = 8'h18;
  localparam logic [7:0]  FAC_OFF_RESULT  = 8'h1c;
  localparam logic [1:0]  FAC_RESP_OKAY   = 2'h0;
  localparam logic [1:0]  FAC_RESP_SLVERR = 2'h2;
  // status bit positions
  localparam int unsigned FAC_ST_DONE  = 0;
  localparam int unsigned FAC_ST_FAULT = 1;
  localparam int unsigned FAC_ST_SAVE  = 2;
  typedef enum logic [1:0] {
    FAC_OP_EXEC  = 2'h0,
    FAC_OP_RDSYS = 2'h1,
    FAC_OP_WRSYS = 2'h2
  } fac_op_t;
  typedef enum logic [1:0] {
    FAC_ST_IDLE = 2'b00,
    FAC_ST_REQ  = 2'b01,
    FAC_ST_WAIT = 2'b11
  } fac_hstate_t;

  // field decode used by the device end
  function automatic logic fac_permitted(input logic [1:0] fld,
                                         input logic priv);
    return (fld == FAC_ACC_FULL) || (fld == FAC_ACC_PRIV && priv);
  endfunction : fac_permitted
endpackage : fac_pkg
`default_nettype wire

// file: logic/fac_regbank.sv
// single and double precision register bank of the fp extension
`default_nettype none
module fac_regbank
  import fac_pkg::*;
(
  input  wire  logic        ref_clk,
  input  wire  logic        reset,
  input  wire  logic        wr_en,
  input  wire  logic [4:0]  wr_sidx,
  input  wire  logic [31:0] wr_data,
  input  wire  logic [4:0]  rd_sidx,
  input  wire  logic [3:0]  rd_didx,
  output logic [31:0]       rd_sdata,
  output logic [63:0]       rd_ddata
);
  logic [31:0] sreg_ff [FAC_NUM_SREG];

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < FAC_NUM_SREG; i++) begin
        sreg_ff[i] <= 32'h0000_0000;
      end
    end else if (wr_en) begin
      sreg_ff[wr_sidx] <= wr_data;
    end
  end

  // double view pairs s(2n+1):s(2n)
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rd_sdata <= 32'h0000_0000;
      rd_ddata <= 64'h0;
    end else begin
      rd_sdata <= sreg_ff[rd_sidx];
      rd_ddata <= {sreg_ff[{rd_didx, 1'b1}], sreg_ff[{rd_didx, 1'b0}]};
    end
  end
endmodule : fac_regbank
`default_nettype wire

// file: testbench/fac_check_props.sv
// concurrent checks on the interface joining the two ends of the unit
`default_nettype none
module fac_check_props
  import fac_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        reset,
  input wire logic        req_valid,
  input wire logic        req_ready,
  input wire logic [1:0]  req_op,
  input wire logic        req_priv,
  input wire logic [3:0]  req_idx,
  input wire logic [1:0]  access_lo,
  input wire logic        auto_preserve_enable,
  input wire logic        lazy_preserve_active,
  input wire logic        rsp_valid,
  input wire logic        rsp_usage_fault_a,
  input wire logic        rsp_no_coprocessor_flag,
  input wire logic        rsp_reserved,
  input wire logic [31:0] rsp_rdata,
  input wire logic        fp_context_active
);
  logic take_ex;
  logic take_sys;
  logic deny;
  logic lazy;
  assign take_ex = req_valid && req_ready && req_op == FAC_OP_EXEC;
  assign take_sys = req_valid && req_ready && req_op != FAC_OP_EXEC;
  // field 10 is handled as a denial
  assign deny = access_lo == FAC_ACC_DENY || access_lo == FAC_ACC_RSVD
    || (access_lo == FAC_ACC_PRIV && !req_priv);
  assign lazy = lazy_preserve_active;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);

  property p_deny;
    take_ex && deny |=> rsp_valid && rsp_usage_fault_a
      && rsp_no_coprocessor_flag;
  endproperty
  a_deny: assert property (p_deny) else $error("denial not faulted");
  property p_wait;
    take_ex && !deny |=> !rsp_valid && !req_ready;
  endproperty
  a_wait: assert property (p_wait) else $error("exec answered early");
  property p_grant;
    take_ex && !deny && !lazy ##1 !lazy |=> rsp_valid && !rsp_usage_fault_a;
  endproperty
  a_grant: assert property (p_grant) else $error("grant not answered");
  property p_lazy;
    take_ex && !deny && lazy ##1 lazy |=> !rsp_valid;
  endproperty
  a_lazy: assert property (p_lazy) else $error("ran before save");
  property p_seed;
    take_ex && !deny && !lazy ##1 (!lazy && auto_preserve_enable
      && !fp_context_active) |=> fp_context_active;
  endproperty
  a_seed: assert property (p_seed) else $error("context not set");
  property p_noseed;
    !auto_preserve_enable |=> !$rose(fp_context_active);
  endproperty
  a_noseed: assert property (p_noseed) else $error("context set");
  property p_rsvd;
    take_sys && req_op == FAC_OP_RDSYS && access_lo == FAC_ACC_FULL
      && req_idx != FAC_IDX_STATUS_CONTROL
      |=> rsp_valid && rsp_reserved && rsp_rdata == 32'h0;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved index used");
  property p_sys;
    take_sys && access_lo == FAC_ACC_FULL && req_idx == FAC_IDX_STATUS_CONTROL
      |=> rsp_valid && !rsp_reserved && !rsp_usage_fault_a;
  endproperty
  a_sys: assert property (p_sys) else $error("sysreg access refused");
  property p_sticky;
    rsp_no_coprocessor_flag |=> rsp_no_coprocessor_flag;
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag dropped");
endmodule : fac_check_props
`default_nettype wire

// file: testbench/tb_fp_access_check_unit.sv
// self-checking bench: host and device ends joined through the interface
`default_nettype none
module tb_fp_access_check_unit
  import fac_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        ref_clk = 1'h0, reset = 1'h1, bank_wr_en = 1'h0;
  logic [7:0]  s_awaddr = 8'h0, s_araddr = 8'h0;
  logic [31:0] s_wdata = 32'h0, bank_wr_data = 32'h0;
  logic [3:0]  s_wstrb = 4'hf, bank_rd_didx = 4'h0;
  logic        s_awvalid = 1'h0, s_wvalid = 1'h0, s_bready = 1'h0;
  logic        s_arvalid = 1'h0, s_rready = 1'h0;
  logic [4:0]  bank_wr_sidx = 5'h0, bank_rd_sidx = 5'h0;
  logic        s_awready, s_wready, s_bvalid, s_arready, s_rvalid, irq, no_coprocessor_flag;
  logic [1:0]  s_bresp, s_rresp;
  logic        fmis;
  logic [31:0] s_rdata, bank_rd_sdata, fp_status_control, st, d, sc;
  logic [63:0] bank_rd_ddata;
  int          num_errors = 0, samples_checked = 0;

  always #25 ref_clk = ~ref_clk;

  fac_if fac_if_i ();
  fac_check_dev fac_check_dev_i (.ref_clk, .reset, .fif(fac_if_i),
    .bank_wr_en, .bank_wr_sidx, .bank_wr_data, .bank_rd_sidx, .bank_rd_didx,
    .bank_rd_sdata, .bank_rd_ddata, .fp_status_control,
    .usage_fault_status_no_coprocessor_flag(no_coprocessor_flag), .fields_mismatch(fmis));
  fac_ctrl_host fac_ctrl_host_i (.ref_clk, .reset, .fif(fac_if_i), .s_awaddr,
    .s_awvalid, .s_awready, .s_wdata, .s_wstrb, .s_wvalid, .s_wready,
    .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready,
    .s_rdata, .s_rresp, .s_rvalid, .s_rready, .irq);
  fac_check_props fac_check_props_i (.ref_clk, .reset,
    .req_valid(fac_if_i.req_valid), .req_ready(fac_if_i.req_ready),
    .req_op(fac_if_i.req_op), .req_priv(fac_if_i.req_priv),
    .req_idx(fac_if_i.req_idx), .access_lo(fac_if_i.access_lo),
    .auto_preserve_enable(fac_if_i.auto_preserve_enable),
    .lazy_preserve_active(fac_if_i.lazy_preserve_active),
    .rsp_valid(fac_if_i.rsp_valid),
    .rsp_usage_fault_a(fac_if_i.rsp_usage_fault_a),
    .rsp_no_coprocessor_flag(fac_if_i.rsp_no_coprocessor_flag),
    .rsp_reserved(fac_if_i.rsp_reserved), .rsp_rdata(fac_if_i.rsp_rdata),
    .fp_context_active(fac_if_i.fp_context_active));

  task automatic chk_w(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk_w
  task automatic chk_r(input logic [1:0] g, input logic [1:0] e);
    chk_w({30'h0, g}, {30'h0, e});
  endtask : chk_r

  // flags are kept locally: our own nonblocking updates land too late
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v,
                        output logic [1:0] r);
    bit aw = 1'h1;
    bit w = 1'h1;
    bit b = 1'h1;
    int n = 0;
    r = 2'h1;
    @(posedge ref_clk);
    s_awaddr <= a;
    s_wdata <= v;
    s_awvalid <= 1'h1;
    s_wvalid <= 1'h1;
    s_bready <= 1'h1;
    while (b && n < 100) begin
      @(posedge ref_clk);
      n++;
      if (aw && s_awready) begin
        aw = 1'h0;
        s_awvalid <= 1'h0;
      end
      if (w && s_wready) begin
        w = 1'h0;
        s_wvalid <= 1'h0;
      end
      if (s_bvalid) begin
        b = 1'h0;
        r = s_bresp;
        s_bready <= 1'h0;
      end
    end
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] v,
                        output logic [1:0] r);
    bit ar = 1'h1;
    int n = 0;
    r = 2'h1;
    v = 32'h0;
    @(posedge ref_clk);
    s_araddr <= a;
    s_arvalid <= 1'h1;
    s_rready <= 1'h1;
    while (r === 2'h1 && n < 100) begin
      @(posedge ref_clk);
      n++;
      if (ar && s_arready) begin
        ar = 1'h0;
        s_arvalid <= 1'h0;
      end
      if (s_rvalid) begin
        r = s_rresp;
        v = s_rdata;
        s_rready <= 1'h0;
      end
    end
  endtask : axi_rd
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic [1:0] r;
    axi_wr(a, v, r);
    chk_r(r, FAC_RESP_OKAY);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    logic [1:0] r;
    axi_rd(a, v, r);
    chk_r(r, FAC_RESP_OKAY);
  endtask : rd
  task automatic wait_op(output logic [31:0] s);
    int n = 0;
    s = 32'h0;
    while (s[1:0] === 2'h0 && n < 50) begin
      rd(FAC_OFF_STATUS, s);
      n++;
    end
  endtask : wait_op
  task automatic op(input logic [1:0] o, input logic [3:0] i,
                    output logic [31:0] s);
    // a stale done bit would end the wait before this command finishes
    wr(FAC_OFF_STATUS, 32'h7);
    wr(FAC_OFF_CMD, {26'h0, i, o});
    wait_op(s);
  endtask : op
  task automatic irq_is(input logic e);
    repeat (2) @(posedge ref_clk);
    chk_w({31'h0, irq}, {31'h0, e});
  endtask : irq_is

  task automatic t_sys();
    logic [3:0] rsv [3] = '{4'h0, 4'h2, 4'hf};
    chk_w(fp_status_control, FAC_STATUS_CONTROL_RST);
    wr(FAC_OFF_ACCESS, 32'hf);
    chk_w({31'h0, fmis}, 32'h0);
    wr(FAC_OFF_CTRL, 32'h8);
    wr(FAC_OFF_SYSREG, 32'h1234_5678);
    op(FAC_OP_WRSYS, FAC_IDX_STATUS_CONTROL, st);
    chk_w(fp_status_control, 32'h1234_5678);
    op(FAC_OP_RDSYS, FAC_IDX_STATUS_CONTROL, st);
    rd(FAC_OFF_RESULT, d);
    chk_w(d, 32'h1234_5678);
    wr(FAC_OFF_SYSREG, 32'hdead_beef);
    foreach (rsv[i]) begin
      op(FAC_OP_WRSYS, rsv[i], st);
      op(FAC_OP_RDSYS, rsv[i], st);
      rd(FAC_OFF_CMD, d);
      chk_w({31'h0, d[6]}, 32'h1);
      rd(FAC_OFF_RESULT, d);
      chk_w(d, 32'h0);
      chk_w(fp_status_control, 32'h1234_5678);
    end
    wr(FAC_OFF_STATUS, 32'h7);
  endtask : t_sys
  task automatic t_seed();
    sc = 32'h1234_5678;
    sc[FAC_DEFAULT_HI:FAC_DEFAULT_LO] = 5'h1f;
    wr(FAC_OFF_DEFAULT, 32'hffff_ffff);
    wr(FAC_OFF_CTRL, 32'h1);
    op(FAC_OP_EXEC, 4'h0, st);
    chk_w(st & 32'h13, 32'h11);
    chk_w(fp_status_control, sc);
    wr(FAC_OFF_DEFAULT, 32'h0);
    op(FAC_OP_EXEC, 4'h0, st);
    chk_w(fp_status_control, sc);
    wr(FAC_OFF_STATUS, 32'h7);
  endtask : t_seed
  task automatic t_lazy();
    wr(FAC_OFF_CTRL, 32'h2);
    wr(FAC_OFF_CMD, {30'h0, FAC_OP_EXEC});
    // save-wait bit reaches status two edges after the request is taken
    repeat (2) @(posedge ref_clk);
    rd(FAC_OFF_STATUS, st);
    chk_w(st & 32'h7, 32'h4);
    wr(FAC_OFF_CTRL, 32'h0);
    wait_op(st);
    chk_w(st & 32'h3, 32'h1);
    wr(FAC_OFF_STATUS, 32'h7);
  endtask : t_lazy
  task automatic t_deny();
    logic [3:0] acc [4] = '{4'h0, 4'h5, 4'h5, 4'ha};
    logic       pv [4] = '{1'h1, 1'h0, 1'h1, 1'h1};
    logic       dn [4] = '{1'h1, 1'h1, 1'h0, 1'h1};
    foreach (acc[i]) begin
      wr(FAC_OFF_ACCESS, {28'h0, acc[i]});
      wr(FAC_OFF_CTRL, {28'h0, pv[i], 3'h0});
      op(FAC_OP_EXEC, 4'h0, st);
      chk_w({31'h0, st[1]}, {31'h0, dn[i]});
      chk_w({31'h0, st[3] & no_coprocessor_flag}, 32'h1);
      chk_w(fp_status_control, sc);
      irq_is(1'h0);
      wr(FAC_OFF_MASK, 32'h7);
      irq_is(1'h1);
      wr(FAC_OFF_STATUS, 32'h7);
      irq_is(1'h0);
      wr(FAC_OFF_MASK, 32'h0);
    end
  endtask : t_deny
  task automatic t_axi();
    logic [1:0] r;
    axi_rd(8'h20, d, r);
    chk_r(r, FAC_RESP_SLVERR);
    chk_w(d, 32'h0);
    axi_wr(8'h1c, 32'h1, r);
    chk_r(r, FAC_RESP_SLVERR);
    axi_wr(8'h02, 32'h1, r);
    chk_r(r, FAC_RESP_SLVERR);
  endtask : t_axi
  task automatic t_bank();
    @(posedge ref_clk);
    bank_wr_en <= 1'h1;
    bank_wr_sidx <= 5'h2;
    bank_wr_data <= 32'haaaa_0001;
    @(posedge ref_clk);
    bank_wr_sidx <= 5'h3;
    bank_wr_data <= 32'hbbbb_0002;
    @(posedge ref_clk);
    bank_wr_en <= 1'h0;
    bank_rd_didx <= 4'h1;
    bank_rd_sidx <= 5'h3;
    repeat (2) @(posedge ref_clk);
    chk_w(bank_rd_ddata[63:32], 32'hbbbb_0002);
    chk_w(bank_rd_ddata[31:0], 32'haaaa_0001);
    chk_w(bank_rd_sdata, 32'hbbbb_0002);
  endtask : t_bank

  task automatic end_of_test();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_of_test

  initial begin
    repeat (6) @(posedge ref_clk);
    reset <= 1'h0;
    t_sys();
    t_seed();
    t_lazy();
    t_deny();
    t_axi();
    t_bank();
    end_of_test();
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    num_errors++;
    end_of_test();
  end
endmodule : tb_fp_access_check_unit
`default_nettype wire
